// File: can_err_defines.vh
`ifndef CAN_ERR_DEFINES_VH
`define CAN_ERR_DEFINES_VH
`define ADDR_TX_ERR_COUNT   6'h1C
`define ADDR_RX_ERR_COUNT   6'h1D
`define ADDR_IRQ_ENABLE     6'h2B
`define ADDR_IRQ_FLAG       6'h2C
`define ADDR_ERROR_FLAG     6'h2D
`define ADDR_STATUS         6'h2E
`define ADDR_CONTROL        6'h2F
`define RESET_BYTE          8'h00
`define LIMIT_WARNING       8'h60
`define LIMIT_PASSIVE       8'h80
`define LIMIT_BUS_OFF       8'hFF
`define BIT_BUF1_OVR        7
`define BIT_BUF0_OVR        6
`define BIT_BUS_OFF         5
`define BIT_TX_PASSIVE      4
`define BIT_RX_PASSIVE      3
`define BIT_TX_WARNING      2
`define BIT_RX_WARNING      1
`define BIT_ANY_WARNING     0
`define IRQ_MSG_ERR         7
`define IRQ_WAKE            6
`define IRQ_ERR_STATE       5
`define IRQ_TX2             4
`define IRQ_TX1             3
`define IRQ_TX0             2
`define IRQ_RX1             1
`define IRQ_RX0             0
`define CODE_NONE           3'h0
`define CODE_ERR            3'h1
`define CODE_WAKE           3'h2
`define CODE_TX0            3'h3
`define CODE_TX1            3'h4
`define CODE_TX2            3'h5
`define CODE_RX0            3'h6
`define CODE_RX1            3'h7
`define MODE_NORMAL         3'h0
`define MODE_SLEEP          3'h1
`define MODE_LISTEN         3'h3
`endif

// File: error_status.v
`timescale 1ns/1ps
`default_nettype none
`include "can_err_defines.vh"
module error_status (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire [7:0] tx_error_count,
	input  wire [7:0] rx_error_count,
	input  wire       bus_recovered,
	input  wire [1:0] ovr_event,
	input  wire [1:0] ovr_clear,
	output wire [7:0] error_flag_reg,
	output wire       state_changed
);
	reg  [1:0] buffer_overflow_flag;
	reg        bus_off_flag;
	reg  [5:0] prev_state;
	wire [5:0] state;
	wire       tx_passive_flag;
	wire       rx_passive_flag;
	wire       tx_warning_flag;
	wire       rx_warning_flag;
	wire       any_warning_flag;

	assign tx_passive_flag  = tx_error_count >= `LIMIT_PASSIVE;
	assign rx_passive_flag  = rx_error_count >= `LIMIT_PASSIVE;
	assign tx_warning_flag  = tx_error_count >= `LIMIT_WARNING;
	assign rx_warning_flag  = rx_error_count >= `LIMIT_WARNING;
	assign any_warning_flag = tx_warning_flag | rx_warning_flag;
	assign state = {bus_off_flag, tx_passive_flag, rx_passive_flag,
		tx_warning_flag, rx_warning_flag, any_warning_flag};
	assign error_flag_reg = {buffer_overflow_flag, state};
	assign state_changed = state != prev_state;

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_ovr
			always @(posedge mclk) begin
				if (!rst_n)
					buffer_overflow_flag[i] <= 1'b0;
				else if (ovr_event[i])
					buffer_overflow_flag[i] <= 1'b1;
				else if (ovr_clear[i])
					buffer_overflow_flag[i] <= 1'b0;
			end
		end
	endgenerate

	always @(posedge mclk) begin
		if (!rst_n) begin
			bus_off_flag <= 1'b0;
			prev_state   <= 6'h00;
		end else begin
			prev_state <= state;
			if (tx_error_count == `LIMIT_BUS_OFF)
				bus_off_flag <= 1'b1;
			else if (bus_recovered)
				bus_off_flag <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: irq_priority.v
`timescale 1ns/1ps
`default_nettype none
`include "can_err_defines.vh"
module irq_priority (
	input  wire [7:0] pending,
	output reg  [2:0] irq_source_code
);
	// Lower code wins; message error has no code of its own.
	always @* begin
		if (pending[`IRQ_ERR_STATE])
			irq_source_code = `CODE_ERR;
		else if (pending[`IRQ_WAKE])
			irq_source_code = `CODE_WAKE;
		else if (pending[`IRQ_TX0])
			irq_source_code = `CODE_TX0;
		else if (pending[`IRQ_TX1])
			irq_source_code = `CODE_TX1;
		else if (pending[`IRQ_TX2])
			irq_source_code = `CODE_TX2;
		else if (pending[`IRQ_RX0])
			irq_source_code = `CODE_RX0;
		else if (pending[`IRQ_RX1])
			irq_source_code = `CODE_RX1;
		else
			irq_source_code = `CODE_NONE;
	end
endmodule
`default_nettype wire

// File: can_error_flags_and_interrupts.v
// How it works
// - Read-only receive error count at 1Dh.
// - Buffer 1 overflow sets, host clears.
// - Buffer 0 overflow sets, host clears.
// - Bus-off at 255, cleared by recovery.
// - Transmit passive while count at least 128.
// - Receive passive while count at least 128.
// - Transmit warning while count at least 96.
// - Receive warning while count at least 96.
// - Combined warning is OR of both.
// - Eight sources, each enable and flag.
// - Interrupt pin low while enabled flag pending.
// - Clearing ignored while setting condition persists.
// - Host may set flags, raising interrupts.
// - Priority source code, lower code wins.
// - Transmit buffer empty sets its flag.
// - Receive buffer full flag after frame end.
// - Message error sets flag, interrupt if enabled.
// - Bus activity in sleep with wake enabled sets wake, exits.
// - Wake from sleep enters listen-only.
// - Overflow or state change sets error flag.
// - Overflow when matched buffer cannot load.
// - Read-only transmit error count at 1Ch.
// - Flag bit order: error, wake, state, buffers.
`timescale 1ns/1ps
`default_nettype none
`include "can_err_defines.vh"
module can_error_flags_and_interrupts (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire [7:0]  tx_error_count,
	input  wire [7:0]  rx_error_count,
	input  wire        bus_recovered,
	input  wire [2:0]  tx_buf_empty,
	input  wire [1:0]  rx_buf_loaded,
	input  wire [1:0]  rx_msg_accepted,
	input  wire        msg_error,
	input  wire        bus_activity,
	output wire        int_n,
	output wire [2:0]  irq_source_code,
	output wire [2:0]  op_mode
);
	localparam ST_IDLE = 2'b01;
	localparam ST_DONE = 2'b10;

	reg  [1:0]  bus_state;
	reg  [7:0]  irq_enable_reg;
	reg  [7:0]  irq_flag_reg;
	reg  [7:0]  next_irq_flag;
	reg  [2:0]  mode;
	reg  [2:0]  next_mode;
	reg  [31:0] next_readdata;
	reg  [7:0]  irq_set;
	reg  [7:0]  irq_hold;
	wire [7:0]  error_flag_reg;
	wire        state_changed;
	wire [1:0]  ovr_event;
	wire [1:0]  ovr_clear;
	wire [7:0]  pending;
	wire        wr_req;
	wire        rd_req;
	wire        wake_event;
	wire [7:0]  status_reg;

	// Every access takes one wait cycle, then completes.
	assign avs_waitrequest = (avs_read | avs_write) & (bus_state != ST_DONE);
	assign wr_req = avs_write & (bus_state == ST_DONE) & avs_byteenable[0];
	assign rd_req = avs_read & (bus_state == ST_IDLE);

	always @(posedge mclk) begin
		if (!rst_n)
			bus_state <= ST_IDLE;
		else begin
			case (bus_state)
				ST_IDLE: begin
					if (avs_read | avs_write)
						bus_state <= ST_DONE;
				end
				ST_DONE: bus_state <= ST_IDLE;
				default: bus_state <= ST_IDLE;
			endcase
		end
	end

	// Overflow: accepted message whose buffer is still full.
	assign ovr_event = rx_msg_accepted & irq_flag_reg[`IRQ_RX1:`IRQ_RX0];
	assign ovr_clear = {2{wr_req && avs_address == `ADDR_ERROR_FLAG}} &
		~avs_writedata[`BIT_BUF1_OVR:`BIT_BUF0_OVR];

	error_status u_error_status (
		.mclk           (mclk),
		.rst_n          (rst_n),
		.tx_error_count (tx_error_count),
		.rx_error_count (rx_error_count),
		.bus_recovered  (bus_recovered),
		.ovr_event      (ovr_event),
		.ovr_clear      (ovr_clear),
		.error_flag_reg (error_flag_reg),
		.state_changed  (state_changed)
	);

	assign wake_event = (mode == `MODE_SLEEP) & irq_enable_reg[`IRQ_WAKE] & bus_activity;

	always @* begin
		irq_set = 8'h00;
		irq_set[`IRQ_MSG_ERR]          = msg_error;
		irq_set[`IRQ_WAKE]             = wake_event;
		irq_set[`IRQ_ERR_STATE]        = state_changed | (|ovr_event);
		irq_set[`IRQ_TX2:`IRQ_TX0]     = tx_buf_empty;
		irq_set[`IRQ_RX1:`IRQ_RX0]     = rx_buf_loaded;
		irq_hold = irq_set;
		irq_hold[`IRQ_ERR_STATE]       = irq_set[`IRQ_ERR_STATE] | (|error_flag_reg[7:6]);
	end

	// Host write replaces flags, but a live condition keeps its flag.
	always @* begin
		next_irq_flag = irq_flag_reg;
		if (wr_req && avs_address == `ADDR_IRQ_FLAG)
			next_irq_flag = avs_writedata[7:0] | (irq_flag_reg & irq_hold);
		next_irq_flag = next_irq_flag | irq_set;
	end

	always @* begin
		next_mode = mode;
		if (wr_req && avs_address == `ADDR_CONTROL)
			next_mode = avs_writedata[2:0];
		if (wake_event)
			next_mode = `MODE_LISTEN;
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			irq_enable_reg <= `RESET_BYTE;
			irq_flag_reg   <= `RESET_BYTE;
			mode           <= `MODE_NORMAL;
		end else begin
			irq_flag_reg <= next_irq_flag;
			mode         <= next_mode;
			if (wr_req && avs_address == `ADDR_IRQ_ENABLE)
				irq_enable_reg <= avs_writedata[7:0];
		end
	end

	assign pending = irq_flag_reg & irq_enable_reg;
	assign int_n = ~(|pending);
	assign op_mode = mode;

	irq_priority u_irq_priority (
		.pending         (pending),
		.irq_source_code (irq_source_code)
	);

	assign status_reg = {irq_source_code, 2'b00, mode};

	always @* begin
		case (avs_address)
			`ADDR_TX_ERR_COUNT: next_readdata = {24'h000000, tx_error_count};
			`ADDR_RX_ERR_COUNT: next_readdata = {24'h000000, rx_error_count};
			`ADDR_IRQ_ENABLE:   next_readdata = {24'h000000, irq_enable_reg};
			`ADDR_IRQ_FLAG:     next_readdata = {24'h000000, irq_flag_reg};
			`ADDR_ERROR_FLAG:   next_readdata = {24'h000000, error_flag_reg};
			`ADDR_STATUS:       next_readdata = {24'h000000, status_reg};
			`ADDR_CONTROL:      next_readdata = {29'h00000000, mode};
			default:            next_readdata = 32'h00000000;
		endcase
	end

	always @(posedge mclk) begin
		if (!rst_n)
			avs_readdata <= 32'h00000000;
		else if (rd_req)
			avs_readdata <= next_readdata;
	end
endmodule
`default_nettype wire

// File: can_err_chk.sv
`timescale 1ns/1ps
`default_nettype none
module can_err_chk (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [7:0]  tx_error_count,
	input wire logic [7:0]  rx_error_count,
	input wire logic        int_n,
	input wire logic [2:0]  irq_source_code,
	input wire logic [2:0]  op_mode
);
	wire logic rd_done = avs_read && !avs_waitrequest;
	wire logic rd_flag = rd_done && avs_address == 6'h2D;
	wire logic tw      = tx_error_count >= 8'h60;
	wire logic rw      = rx_error_count >= 8'h60;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("second wait cycle");
	a_rx_count: assert property (rd_done && avs_address == 6'h1D |-> avs_readdata[7:0] == rx_error_count)
		else $error("rx count read");
	a_tx_count: assert property (rd_done && avs_address == 6'h1C |-> avs_readdata[7:0] == tx_error_count)
		else $error("tx count read");
	a_warn_bits: assert property (rd_flag |-> avs_readdata[2:0] == {tw, rw, tw || rw})
		else $error("warning bits");
	a_passive_bits: assert property (rd_flag |-> avs_readdata[4:3] == {tx_error_count[7], rx_error_count[7]})
		else $error("passive bits");
	a_bus_off: assert property (rd_flag && tx_error_count == 8'hFF |-> avs_readdata[5])
		else $error("bus off bit");
	a_code_int: assert property (irq_source_code != 3'h0 |-> !int_n)
		else $error("code without interrupt");
	a_int_release: assert property ($rose(int_n) |-> $past(avs_write && !avs_waitrequest))
		else $error("interrupt released without write");
	cover property (rd_flag);
	cover property (!int_n);
	cover property (op_mode == 3'h3);
endmodule
bind can_error_flags_and_interrupts can_err_chk u_can_err_chk (.*);
`default_nettype wire

// File: engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module engine_model (
	input  wire logic       mclk,
	output wire logic [7:0] tx_error_count,
	output wire logic [7:0] rx_error_count,
	output wire logic       bus_recovered,
	output wire logic [2:0] tx_buf_empty,
	output wire logic [1:0] rx_buf_loaded,
	output wire logic [1:0] rx_msg_accepted,
	output wire logic       msg_error,
	output wire logic       bus_activity
);
	logic [9:0]  ev  = 10'h000;
	logic [15:0] cnt = 16'h0000;
	assign {tx_error_count, rx_error_count} = cnt;
	assign {bus_activity, msg_error, rx_msg_accepted, rx_buf_loaded, tx_buf_empty, bus_recovered} = ev;
	task automatic fire(input logic [9:0] v, input logic keep);
		ev <= v;
		@(posedge mclk);
		if (!keep)
			ev <= 10'h000;
	endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'h0;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, int_n, bus_recovered, msg_error, bus_activity;
	wire  [2:0]  irq_source_code, op_mode, tx_buf_empty;
	wire  [7:0]  tx_error_count, rx_error_count;
	wire  [1:0]  rx_buf_loaded, rx_msg_accepted;
	int          bad_count = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [31:0] q;
	logic [7:0]  m;
	logic [7:0]  tv [5] = '{8'h5F, 8'h60, 8'h7F, 8'h80, 8'h00};
	logic [7:0]  rv [5] = '{8'h60, 8'h5F, 8'h80, 8'h7F, 8'hFE};
	int          ob [5] = '{2, 3, 4, 0, 1};
	can_error_flags_and_interrupts u_can_error_flags_and_interrupts (.*);
	engine_model u_engine_model (.*);
	initial forever #5 mclk = ~mclk;
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] e);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= e;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] x);
		bus(1'b0, a, 8'h00, 4'h0);
		cmp(q, {24'h000000, x});
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask
	task automatic see(input logic [2:0] c, input logic i);
		@(posedge mclk);
		cmp({28'h0000000, int_n, irq_source_code}, {28'h0000000, i, c});
	endtask
	task automatic cnt(input logic [7:0] t, input logic [7:0] r);
		u_engine_model.cnt <= {t, r};
		repeat (2) @(posedge mclk);
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(6'h2B, 8'h00);
		rd(6'h2C, 8'h00);
		rd(6'h2D, 8'h00);
		rd(6'h10, 8'h00);
		cnt(8'h5A, 8'hA5);
		wr(6'h1D, 8'hFF);
		rd(6'h1D, 8'hA5);
		rd(6'h1C, 8'h5A);
		for (int i = 0; i < 5; i++) begin
			cnt(tv[i], rv[i]);
			wr(6'h2D, 8'h3F);
			m = {3'h0, tv[i] >= 8'h80, rv[i] >= 8'h80, tv[i] >= 8'h60, rv[i] >= 8'h60, 1'b0};
			m[0] = m[1] | m[2];
			rd(6'h2D, m);
		end
		cnt(8'hFF, 8'h00);
		rd(6'h2D, 8'h35);
		cnt(8'h00, 8'h00);
		rd(6'h2D, 8'h20);
		u_engine_model.fire(10'h001, 1'b0);
		rd(6'h2D, 8'h00);
		wr(6'h2C, 8'h00);
		wr(6'h2B, 8'hFF);
		u_engine_model.fire(10'h03E, 1'b0);
		rd(6'h2C, 8'h1F);
		m = 8'h1F;
		for (int i = 0; i < 5; i++) begin
			see(3'(i + 3), 1'b0);
			m[ob[i]] = 1'b0;
			wr(6'h2C, m);
		end
		see(3'h0, 1'b1);
		u_engine_model.fire(10'h002, 1'b1);
		wr(6'h2C, 8'h00);
		rd(6'h2C, 8'h04);
		u_engine_model.fire(10'h000, 1'b0);
		wr(6'h2C, 8'h00);
		wr(6'h2B, 8'h00);
		u_engine_model.fire(10'h100, 1'b0);
		rd(6'h2C, 8'h80);
		see(3'h0, 1'b1);
		wr(6'h2B, 8'h80);
		see(3'h0, 1'b0);
		wr(6'h2C, 8'h01);
		see(3'h0, 1'b1);
		wr(6'h2B, 8'h01);
		see(3'h6, 1'b0);
		for (int i = 0; i < 2; i++) begin
			wr(6'h2C, 8'h00);
			u_engine_model.fire(10'h040 << i, 1'b0);
			rd(6'h2D, 8'h00);
			u_engine_model.fire(10'h010 << i, 1'b0);
			u_engine_model.fire(10'h040 << i, 1'b0);
			rd(6'h2D, 8'h40 << i);
			rd(6'h2C, 8'h20 | (8'h01 << i));
			wr(6'h2C, 8'h00);
			rd(6'h2C, 8'h20);
			wr(6'h2D, 8'h00);
			rd(6'h2D, 8'h00);
		end
		bus(1'b1, 6'h2B, 8'hFF, 4'h0);
		rd(6'h2B, 8'h01);
		wr(6'h2C, 8'h00);
		wr(6'h2B, 8'h40);
		u_engine_model.fire(10'h200, 1'b0);
		rd(6'h2C, 8'h00);
		wr(6'h2F, 8'h01);
		u_engine_model.fire(10'h200, 1'b0);
		rd(6'h2C, 8'h40);
		rd(6'h2E, 8'h43);
		see(3'h2, 1'b0);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		see(3'h0, 1'b1);
		rd(6'h2C, 8'h00);
		rd(6'h2F, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
